// file: logic/vc_arb_pkg.sv
`default_nettype none
package vc_arb_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] STATUS_OFFSET      = 12'h218;
  localparam logic [11:0] TABLE_WORD0_OFFSET = 12'h220;
  localparam logic [11:0] TABLE_WORD1_OFFSET = 12'h224;
  localparam logic [11:0] CONTROL_OFFSET     = 12'h214;
  localparam logic [11:0] IRQ_STATUS_OFFSET  = 12'h230;
  localparam logic [11:0] IRQ_ENABLE_OFFSET  = 12'h234;
  localparam logic [11:0] IRQ_CLEAR_OFFSET   = 12'h238;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int COHERENCY_BIT   = 16;
  localparam int NEG_PENDING_BIT = 17;
  localparam int LOAD_TABLE_BIT  = 16;
  localparam int ARB_SEL_LSB     = 17;
  localparam int ARB_SEL_WIDTH   = 3;
  localparam int PHASE_WIDTH     = 4;
  localparam int PHASE_COUNT     = 16;
  localparam int PHASES_PER_WORD = 8;

  // Interrupt event bit positions
  localparam int IRQ_LOAD_DONE_BIT = 0;
  localparam int IRQ_NEG_DONE_BIT  = 1;
  localparam int IRQ_WIDTH         = 2;

  // ****************************************************************
  // Reset values and port codes
  // ****************************************************************
  localparam logic [31:0] TABLE_WORD0_RESET = 32'h1765_4321;
  localparam logic [31:0] TABLE_WORD1_RESET = 32'h2176_5432;
  localparam logic [2:0]  ARB_SEL_RESET     = 3'h0;
  localparam logic [3:0]  PORT_UPSTREAM     = 4'h0;
  localparam logic [3:0]  PORT_TWO          = 4'h2;
  localparam logic [3:0]  PORT_FOUR         = 4'h4;

  // Cycles taken to copy the table into the arbiter
  localparam int LOAD_CYCLES = 2;

endpackage
`default_nettype wire

// file: logic/arb_table_if.sv
`timescale 1ns/1ps
`default_nettype none
// Table handed from the register bank to the phase stepper
interface arb_table_if;
  logic [63:0] table_bits;
  logic        load_req;
  logic        load_done;
  logic        step;
  logic        grant_valid;
  logic [3:0]  grant_port;
  logic [3:0]  phase_index;

  modport bank
  (
    output table_bits,
    output load_req,
    output step,
    input  load_done,
    input  grant_valid,
    input  grant_port,
    input  phase_index
  );

  modport stepper
  (
    input  table_bits,
    input  load_req,
    input  step,
    output load_done,
    output grant_valid,
    output grant_port,
    output phase_index
  );
endinterface
`default_nettype wire

// file: logic/phase_stepper.sv
`timescale 1ns/1ps
`default_nettype none
module phase_stepper
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  arb_table_if.stepper tbl
);

  typedef enum logic [1:0] {LOAD_IDLE, LOAD_COPY, LOAD_DONE} load_state_t;

  load_state_t       load_state_reg;
  logic [63:0]       latched_reg;
  logic [1:0]        copy_cnt_reg;
  logic [3:0]        phase_reg;
  logic              grant_valid_reg;
  logic [3:0]        grant_port_reg;

  // Legal port codes only
  function automatic logic port_valid(input logic [3:0] code);
    return (code == vc_arb_pkg::PORT_UPSTREAM) || (code == vc_arb_pkg::PORT_TWO) ||
           (code == vc_arb_pkg::PORT_FOUR);
  endfunction

  function automatic logic [3:0] entry(input logic [63:0] t, input logic [3:0] idx);
    return t[idx*4 +: 4];
  endfunction

  // Load sequence: copy table after a settle time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      load_state_reg <= LOAD_IDLE;
      copy_cnt_reg   <= 2'h0;
      latched_reg    <= {vc_arb_pkg::TABLE_WORD1_RESET, vc_arb_pkg::TABLE_WORD0_RESET};
    end
    else
    begin
      case (load_state_reg)
        LOAD_IDLE:
        begin
          if (tbl.load_req)
          begin
            load_state_reg <= LOAD_COPY;
            copy_cnt_reg   <= 2'(vc_arb_pkg::LOAD_CYCLES - 1);
          end
        end
        LOAD_COPY:
        begin
          if (copy_cnt_reg == 2'h0)
          begin
            latched_reg    <= tbl.table_bits;
            load_state_reg <= LOAD_DONE;
          end
          else
          begin
            copy_cnt_reg <= copy_cnt_reg - 2'h1;
          end
        end
        default:
        begin
          load_state_reg <= LOAD_IDLE;
        end
      endcase
    end
  end

  assign tbl.load_done = (load_state_reg == LOAD_DONE);

  // Ascending phase walk; an invalid code gives no grant for its period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg       <= 4'h0;
      grant_valid_reg <= 1'b0;
      grant_port_reg  <= 4'h0;
    end
    else if (tbl.step)
    begin
      phase_reg       <= phase_reg + 4'h1;
      grant_valid_reg <= port_valid(entry(latched_reg, phase_reg));
      grant_port_reg  <= entry(latched_reg, phase_reg);
    end
    else
    begin
      grant_valid_reg <= 1'b0;
    end
  end

  assign tbl.grant_valid = grant_valid_reg;
  assign tbl.grant_port  = grant_port_reg;
  assign tbl.phase_index = phase_reg;

endmodule
`default_nettype wire

// file: logic/port_arbitration_table_status.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module port_arbitration_table_status
#(
  parameter bit UPSTREAM_PORT = 1'b1
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        link_dl_active,
  input  wire logic        fc_init2_active,
  input  wire logic        arb_period_tick,
  output logic             grant_valid,
  output logic [3:0]       grant_port,
  output logic [3:0]       phase_index,
  output logic [2:0]       arb_select,
  output logic             irq
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [31:0]                      table_word0_reg;
  logic [31:0]                      table_word1_reg;
  logic                             coherency_reg;
  logic                             neg_pending_reg;
  logic                             fc_init2_prev_reg;
  logic [2:0]                       arb_select_reg;
  logic                             load_pulse_reg;
  logic                             load_busy_reg;
  logic                             load_retry_reg;
  logic                             table_written_prev_reg;
  logic [vc_arb_pkg::IRQ_WIDTH-1:0] irq_status_reg;
  logic [vc_arb_pkg::IRQ_WIDTH-1:0] irq_enable_reg;
  logic [31:0]                      prdata_reg;

  arb_table_if tbl ();

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic wr_en;
  logic rd_en;
  logic hit_table0;
  logic hit_table1;
  logic hit_control;
  logic hit_status;
  logic hit_irq_status;
  logic hit_irq_enable;
  logic hit_irq_clear;
  logic mapped;
  logic table_written;
  logic neg_done;
  logic load_done;
  logic load_request;

  // Single-cycle access phase, so pready is constant high
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;

  always_comb
  begin
    hit_table0     = 1'b0;
    hit_table1     = 1'b0;
    hit_control    = 1'b0;
    hit_status     = 1'b0;
    hit_irq_status = 1'b0;
    hit_irq_enable = 1'b0;
    hit_irq_clear  = 1'b0;
    if (paddr == vc_arb_pkg::TABLE_WORD0_OFFSET)
      hit_table0 = 1'b1;
    else if (paddr == vc_arb_pkg::TABLE_WORD1_OFFSET)
      hit_table1 = 1'b1;
    else if (paddr == vc_arb_pkg::CONTROL_OFFSET)
      hit_control = 1'b1;
    else if (paddr == vc_arb_pkg::STATUS_OFFSET)
      hit_status = 1'b1;
    else if (paddr == vc_arb_pkg::IRQ_STATUS_OFFSET)
      hit_irq_status = 1'b1;
    else if (paddr == vc_arb_pkg::IRQ_ENABLE_OFFSET)
      hit_irq_enable = 1'b1;
    else if (paddr == vc_arb_pkg::IRQ_CLEAR_OFFSET)
      hit_irq_clear = 1'b1;
  end

  assign mapped = hit_table0 || hit_table1 || hit_control || hit_status ||
                  hit_irq_status || hit_irq_enable || hit_irq_clear;

  // Unmapped address answers with an error, never hangs
  assign pslverr = psel && penable && !mapped;

  assign table_written = wr_en && (hit_table0 || hit_table1);

  // ****************************************************************
  // Arbitration table words
  // ****************************************************************
  // Byte-free whole word writes; fields keep their packed order
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      table_word0_reg <= vc_arb_pkg::TABLE_WORD0_RESET;
      table_word1_reg <= vc_arb_pkg::TABLE_WORD1_RESET;
    end
    else if (wr_en && hit_table0)
    begin
      table_word0_reg <= pwdata;
    end
    else if (wr_en && hit_table1)
    begin
      table_word1_reg <= pwdata;
    end
  end

  // ****************************************************************
  // Control: select field and self-clearing load bit
  // ****************************************************************
  // Select field is plain storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arb_select_reg <= vc_arb_pkg::ARB_SEL_RESET;
    end
    else if (wr_en && hit_control)
    begin
      arb_select_reg <= pwdata[vc_arb_pkg::ARB_SEL_LSB +: vc_arb_pkg::ARB_SEL_WIDTH];
    end
  end

  assign arb_select = arb_select_reg;

  // Writing zero or on a downstream port does nothing
  assign load_request = wr_en && hit_control && pwdata[vc_arb_pkg::LOAD_TABLE_BIT] &&
                        UPSTREAM_PORT;

  // The stepper only takes a request while idle, so one that lands during
  // a copy is held and issued afterwards instead of being lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      load_pulse_reg <= 1'b0;
      load_busy_reg  <= 1'b0;
      load_retry_reg <= 1'b0;
    end
    else if (load_done)
    begin
      load_pulse_reg <= load_retry_reg || load_request;
      load_busy_reg  <= load_retry_reg || load_request;
      load_retry_reg <= 1'b0;
    end
    else if (load_request && !load_busy_reg)
    begin
      load_pulse_reg <= 1'b1;
      load_busy_reg  <= 1'b1;
    end
    else
    begin
      load_pulse_reg <= 1'b0;
      load_retry_reg <= load_retry_reg || load_request;
    end
  end

  // ****************************************************************
  // Table write one cycle back
  // ****************************************************************
  // The copy edge comes one cycle before load done, so a write landing on
  // that edge is missing from the copy and must keep the flag set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      table_written_prev_reg <= 1'b0;
    end
    else
    begin
      table_written_prev_reg <= table_written;
    end
  end

  // ****************************************************************
  // Table coherency flag
  // ****************************************************************
  // A table write in the load-done cycle wins: new data not yet copied
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      coherency_reg <= 1'b0;
    end
    else if (!UPSTREAM_PORT)
    begin
      coherency_reg <= 1'b0;
    end
    else if (table_written)
    begin
      coherency_reg <= 1'b1;
    end
    else if (load_done && !table_written_prev_reg)
    begin
      coherency_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Negotiation pending flag
  // ****************************************************************
  // Pending from FC_INIT2 entry until FC_INIT2 is left; zero otherwise, and read as zero while the link is down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      neg_pending_reg   <= 1'b0;
      fc_init2_prev_reg <= 1'b0;
    end
    else
    begin
      fc_init2_prev_reg <= fc_init2_active;
      if (neg_done)
        neg_pending_reg <= 1'b0;
      else if (fc_init2_active)
        neg_pending_reg <= 1'b1;
    end
  end

  assign neg_done = fc_init2_prev_reg && !fc_init2_active;

  // ****************************************************************
  // Interrupt status, enable and clear
  // ****************************************************************
  logic [vc_arb_pkg::IRQ_WIDTH-1:0] irq_events;
  logic [vc_arb_pkg::IRQ_WIDTH-1:0] irq_clear;

  assign irq_events = {neg_done, load_done};
  assign irq_clear  = (wr_en && hit_irq_clear) ? pwdata[vc_arb_pkg::IRQ_WIDTH-1:0] : '0;

  // Set beats clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_reg <= '0;
    end
    else
    begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_enable_reg <= '0;
    end
    else if (wr_en && hit_irq_enable)
    begin
      irq_enable_reg <= pwdata[vc_arb_pkg::IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Registered in the setup cycle so data is ready in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata_reg <= 32'h0000_0000;
      if (hit_table0)
        prdata_reg <= table_word0_reg;
      else if (hit_table1)
        prdata_reg <= table_word1_reg;
      else if (hit_control)
        prdata_reg[vc_arb_pkg::ARB_SEL_LSB +: vc_arb_pkg::ARB_SEL_WIDTH] <= arb_select_reg;
      else if (hit_status)
      begin
        // Coherency flag only meaningful for table-driven schemes
        prdata_reg[vc_arb_pkg::COHERENCY_BIT]   <= coherency_reg;
        prdata_reg[vc_arb_pkg::NEG_PENDING_BIT] <= neg_pending_reg && link_dl_active;
      end
      else if (hit_irq_status)
        prdata_reg[vc_arb_pkg::IRQ_WIDTH-1:0] <= irq_status_reg;
      else if (hit_irq_enable)
        prdata_reg[vc_arb_pkg::IRQ_WIDTH-1:0] <= irq_enable_reg;
    end
  end

  assign prdata = rd_en ? prdata_reg : 32'h0000_0000;

  // ****************************************************************
  // Arbiter table hand-off
  // ****************************************************************
  assign tbl.table_bits = {table_word1_reg, table_word0_reg};
  assign tbl.load_req   = load_pulse_reg;
  assign tbl.step       = arb_period_tick;
  assign load_done      = tbl.load_done;

  // Port codes checked in the stepper against the legal set
  phase_stepper u_stepper
  (
    .pclk    (pclk),
    .presetn (presetn),
    .tbl     (tbl)
  );

  assign grant_valid = tbl.grant_valid;
  assign grant_port  = tbl.grant_port;
  assign phase_index = tbl.phase_index;

endmodule
`default_nettype wire

// file: dv/port_arbitration_table_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Port-level checker
// ********************
module port_arbitration_table_status_assertions
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        link_dl_active,
  input wire logic        fc_init2_active,
  input wire logic        arb_period_tick,
  input wire logic        grant_valid,
  input wire logic [3:0]  grant_port,
  input wire logic [3:0]  phase_index,
  input wire logic [2:0]  arb_select,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Read access decode; status reads singled out
  wire rd_acc = psel && penable && !pwrite;
  wire st_rd  = rd_acc && paddr == vc_arb_pkg::STATUS_OFFSET;

  property p_step;
    arb_period_tick |=> phase_index == $past(phase_index) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("phase index did not step");
  property p_grant;
    arb_period_tick |=> grant_valid == (grant_port inside {4'h0, 4'h2, 4'h4});
  endproperty
  a_grant: assert property (p_grant) else $error("grant valid wrong for code");
  property p_idle;
    !arb_period_tick |=> !grant_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("grant without a period");
  property p_load_rd;
    rd_acc && paddr == vc_arb_pkg::CONTROL_OFFSET |-> !prdata[16];
  endproperty
  a_load_rd: assert property (p_load_rd) else $error("load bit read as one");
  // Table write then status read three cycles later
  property p_coh;
    psel && penable && pwrite && paddr == vc_arb_pkg::TABLE_WORD0_OFFSET ##3 st_rd
      |-> prdata[16];
  endproperty
  a_coh: assert property (p_coh) else $error("coherency flag not set");
  property p_neg_off;
    st_rd && !link_dl_active && !$past(link_dl_active) |-> !prdata[17];
  endproperty
  a_neg_off: assert property (p_neg_off) else $error("pending with link down");
  property p_neg_done;
    st_rd && !fc_init2_active && !$past(fc_init2_active) && !$past(fc_init2_active, 2)
      && !$past(fc_init2_active, 3) |-> !prdata[17];
  endproperty
  a_neg_done: assert property (p_neg_done) else $error("pending after exit");
  property p_rsvd;
    st_rd |-> prdata[15:0] == 16'h0 && prdata[31:18] == 14'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
  property p_unmapped;
    psel && penable && paddr == 12'h3FC |-> pready && pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_sel;
    psel && penable && pwrite && paddr == vc_arb_pkg::CONTROL_OFFSET
      |=> arb_select == $past(pwdata[19:17]);
  endproperty
  a_sel: assert property (p_sel) else $error("select field not stored");
  property p_irq_off;
    psel && penable && pwrite && paddr == vc_arb_pkg::IRQ_ENABLE_OFFSET && pwdata[1:0] == 2'h0
      |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all sources masked");
endmodule

bind port_arbitration_table_status port_arbitration_table_status_assertions chk
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .prdata, .link_dl_active, .fc_init2_active, .arb_period_tick, .grant_valid,
  .grant_port, .phase_index, .arb_select, .irq
);
`default_nettype wire

// file: dv/port_arbitration_table_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module port_arbitration_table_status_bench;
  // ********************
  // Signals and notes
  // ********************
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        link_dl_active = 1'h0, fc_init2_active = 1'h0, arb_period_tick = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, grant_valid, irq, tick_d = 1'h0;
  logic [3:0]  grant_port, phase_index;
  logic [2:0]  arb_select, sel;
  logic [63:0] tbl, lat;
  logic [65:0] rq[$];
  logic [4:0]  gq[$];
  logic [3:0]  oq[$];
  int          fail_count = 0, checks = 0, ph = 0, seed = 32'hF7CD9E00;

  always #10 pclk = ~pclk;

  port_arbitration_table_status dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .link_dl_active, .fc_init2_active, .arb_period_tick, .grant_valid,
    .grant_port, .phase_index, .arb_select, .irq
  );

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Grant results: valid flag and port code
  task automatic cmp_grant(input logic [4:0] got, input logic [4:0] exp);
    cmp({28'h0, got}, {28'h0, exp});
  endtask

  // Level outputs: select field and interrupt
  task automatic cmp_out(input logic [3:0] got, input logic [3:0] exp);
    cmp({29'h0, got}, {29'h0, exp});
  endtask

  task print_verdict;
    // A note never matched means a result that never appeared
    if (rq.size() + gq.size() + oq.size() > 0)
      fail_count++;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer; held until pready, bounded so a hang ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      print_verdict;
    end
    else
    begin
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e,
                    input logic [32:0] m = 33'h1FFFFFFFF);
    rq.push_back({m, e & m});
    apb(1'h0, a, 32'h0);
  endtask

  // Back-to-back periods; notes come from the latched copy only
  task automatic ticks(input int n);
    logic [3:0] e;
    repeat (n)
    begin
      e = lat[4 * ph +: 4];
      gq.push_back({e == 4'h0 || e == 4'h2 || e == 4'h4, e});
      arb_period_tick <= 1'h1;
      ph = (ph + 1) % 16;
      @(posedge pclk);
    end
    arb_period_tick <= 1'h0;
    repeat (2) @(posedge pclk);
  endtask

  // Watcher: oldest note against each result as it appears
  always @(posedge pclk)
  begin
    logic [65:0] n;
    if (psel && penable && !pwrite && pready === 1'h1 && rq.size() > 0)
    begin
      n = rq.pop_front();
      cmp({pslverr, prdata} & n[65:33], n[32:0]);
    end
    if (tick_d && gq.size() > 0)
      cmp_grant({grant_valid, grant_port}, gq.pop_front());
    if (oq.size() > 0)
      cmp_out({arb_select, irq}, oq.pop_front());
    tick_d <= arb_period_tick;
  end

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 16; i++)
      tbl[4 * i +: 4] = 4'(i % 7 + 1);
    lat = tbl;
    rd(vc_arb_pkg::STATUS_OFFSET, 33'h0);
    rd(vc_arb_pkg::TABLE_WORD0_OFFSET, {1'h0, tbl[31:0]});
    rd(vc_arb_pkg::TABLE_WORD1_OFFSET, {1'h0, tbl[63:32]});
    rd(12'h3FC, 33'h100000000);
    apb(1'h1, vc_arb_pkg::STATUS_OFFSET, 32'hFFFFFFFF);
    rd(vc_arb_pkg::STATUS_OFFSET, 33'h0);
    ticks(16);
    // Only legal, non-own ports are programmed
    for (int i = 0; i < 16; i++)
      tbl[4 * i +: 4] = $random(seed) % 2 ? vc_arb_pkg::PORT_TWO : vc_arb_pkg::PORT_FOUR;
    sel = 3'($random(seed));
    apb(1'h1, vc_arb_pkg::TABLE_WORD0_OFFSET, tbl[31:0]);
    rd(vc_arb_pkg::STATUS_OFFSET, 33'h10000);
    apb(1'h1, vc_arb_pkg::TABLE_WORD1_OFFSET, tbl[63:32]);
    rd(vc_arb_pkg::TABLE_WORD0_OFFSET, {1'h0, tbl[31:0]});
    rd(vc_arb_pkg::TABLE_WORD1_OFFSET, {1'h0, tbl[63:32]});
    ticks(8);
    rd(vc_arb_pkg::STATUS_OFFSET, 33'h10000);
    apb(1'h1, vc_arb_pkg::CONTROL_OFFSET, {12'h0, sel, 1'h1, 16'h0});
    oq.push_back({sel, 1'h0});
    rd(vc_arb_pkg::CONTROL_OFFSET, {13'h0, sel, 17'h0}, 33'h1000F0000);
    repeat (vc_arb_pkg::LOAD_CYCLES + 4) @(posedge pclk);
    rd(vc_arb_pkg::STATUS_OFFSET, 33'h0);
    lat = tbl;
    ticks(24);
    rd(vc_arb_pkg::IRQ_STATUS_OFFSET, 33'h1);
    apb(1'h1, vc_arb_pkg::IRQ_ENABLE_OFFSET, 32'h2);
    oq.push_back({sel, 1'h0});
    apb(1'h1, vc_arb_pkg::IRQ_ENABLE_OFFSET, 32'h3);
    oq.push_back({sel, 1'h1});
    apb(1'h1, vc_arb_pkg::IRQ_CLEAR_OFFSET, 32'h1);
    oq.push_back({sel, 1'h0});
    // Negotiation: pending, link down, then exit
    link_dl_active <= 1'h1;
    fc_init2_active <= 1'h1;
    repeat (4) @(posedge pclk);
    rd(vc_arb_pkg::STATUS_OFFSET, 33'h20000);
    link_dl_active <= 1'h0;
    @(posedge pclk);
    rd(vc_arb_pkg::STATUS_OFFSET, 33'h0);
    link_dl_active <= 1'h1;
    fc_init2_active <= 1'h0;
    repeat (4) @(posedge pclk);
    rd(vc_arb_pkg::STATUS_OFFSET, 33'h0);
    rd(vc_arb_pkg::IRQ_STATUS_OFFSET, 33'h2);
    oq.push_back({sel, 1'h1});
    // Masking every source must drop the interrupt
    apb(1'h1, vc_arb_pkg::IRQ_ENABLE_OFFSET, 32'h0);
    oq.push_back({sel, 1'h0});
    repeat (2) @(posedge pclk);
    print_verdict;
  end
endmodule
`default_nettype wire
